// ### hdl/pscb_pkg.sv
package pscb_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0] PSCB_ADDR_CFG = 4'h0;
	localparam logic [3:0] PSCB_ADDR_STAT = 4'h4;
	localparam int PSCB_ADDR_W = 4;
	localparam int PSCB_DATA_W = 32;
	// ------------------------------------------------------------
	// Configuration field positions
	// ------------------------------------------------------------
	localparam int PSCB_BIT_LOOPOUT = 0;
	localparam int PSCB_BIT_SLEEP = 1;
	localparam int PSCB_BIT_PRESKIP = 2;
	localparam int PSCB_BIT_STATE_MACHINE_RESET_BIT = 3;
	localparam int PSCB_BIT_RPDEN = 4;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic PSCB_RST_LOOPOUT = 1'b0;
	localparam logic PSCB_RST_SLEEP = 1'b0;
	localparam logic PSCB_RST_PRESKIP = 1'b1;
	localparam logic PSCB_RST_RPDEN = 1'b1;
	// ------------------------------------------------------------
	// State machine reset pulse length
	// ------------------------------------------------------------
	localparam int PSCB_STATE_MACHINE_RESET_BIT_NS = 160;
	localparam int PSCB_CLK_MHZ = 25;
	localparam int PSCB_STATE_MACHINE_RESET_BIT_CYC = (PSCB_STATE_MACHINE_RESET_BIT_NS * PSCB_CLK_MHZ + 999) / 1000;
	localparam int PSCB_CNT_W = 4;
	localparam logic [1:0] PSCB_RESP_OKAY = 2'b00;
	localparam logic [1:0] PSCB_RESP_SLVERR = 2'b10;
	typedef enum logic [2:0] {
		PSCB_IDLE = 3'b001,
		PSCB_RUN = 3'b010,
		PSCB_DONE = 3'b100
	} pscb_rst_t;
endpackage : pscb_pkg

// ### hdl/pscb_smreset.sv
module pscb_smreset (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic startPulse,
	output logic busy,
	output logic donePulse
);
	import pscb_pkg::*;
	pscb_rst_t state_q, state_d;
	logic [PSCB_CNT_W-1:0] cnt_q, cnt_d;
	localparam logic [PSCB_CNT_W-1:0] LAST = PSCB_CNT_W'(PSCB_STATE_MACHINE_RESET_BIT_CYC - 1);
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		unique case (state_q)
			PSCB_IDLE: begin
				if (startPulse) begin
					state_d = PSCB_RUN;
					cnt_d = '0;
				end
			end
			PSCB_RUN: begin
				if (cnt_q == LAST) begin
					state_d = PSCB_DONE;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			PSCB_DONE: begin
				// Restart here, or a start in this cycle would leave the bit stuck
				if (startPulse) begin
					state_d = PSCB_RUN;
					cnt_d = '0;
				end else begin
					state_d = PSCB_IDLE;
				end
			end
			default: begin
				state_d = PSCB_IDLE;
			end
		endcase
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= PSCB_IDLE;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end
	assign busy = (state_q == PSCB_RUN);
	assign donePulse = (state_q == PSCB_DONE);
endmodule : pscb_smreset

// ### hdl/pscb_top.sv
module pscb_top (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [pscb_pkg::PSCB_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [pscb_pkg::PSCB_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pscb_pkg::PSCB_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [pscb_pkg::PSCB_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic smResetOut,
	output logic preambleSkipOn,
	output logic sleepPowerDown,
	output logic remoteLoopoutOn,
	output logic reducedPowerDownEn
);
	import pscb_pkg::*;
	// ------------------------------------------------------------
	// Write channel capture
	// ------------------------------------------------------------
	logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
	logic [PSCB_ADDR_W-1:0] awAddr_q, awAddr_d;
	logic [PSCB_DATA_W-1:0] wData_q, wData_d;
	logic wStrb0_q, wStrb0_d;
	logic bValid_q, bValid_d;
	logic [1:0] bResp_q, bResp_d;
	logic rValid_q, rValid_d;
	logic [1:0] rResp_q, rResp_d;
	logic [PSCB_DATA_W-1:0] rData_q, rData_d;
	logic loop_q, loop_d, sleep_q, sleep_d, skip_q, skip_d, rpd_q, rpd_d;
	logic smBit_q, smBit_d, smOut_q, smOut_d;
	logic awRdy_q, wRdy_q, arRdy_q;
	logic doWrite, cfgWrite, smStart, smBusy, smDone;
	logic [PSCB_DATA_W-1:0] cfgView;

	function automatic logic [PSCB_DATA_W-1:0] pack_cfg(input logic lp, input logic sl,
			input logic sk, input logic sm, input logic rp);
		logic [PSCB_DATA_W-1:0] v;
		v = '0;
		v[PSCB_BIT_LOOPOUT] = lp;
		v[PSCB_BIT_SLEEP] = sl;
		v[PSCB_BIT_PRESKIP] = sk;
		v[PSCB_BIT_STATE_MACHINE_RESET_BIT] = sm;
		v[PSCB_BIT_RPDEN] = rp;
		return v;
	endfunction : pack_cfg

	assign doWrite = awHeld_q && wHeld_q && !bValid_q;
	// Byte lane 0 holds every field; other lanes are ignored
	assign cfgWrite = doWrite && (awAddr_q == PSCB_ADDR_CFG) && wStrb0_q;
	assign cfgView = pack_cfg(loop_q, sleep_q, skip_q, smBit_q, rpd_q);

	always_comb begin
		awHeld_d = awHeld_q;
		wHeld_d = wHeld_q;
		awAddr_d = awAddr_q;
		wData_d = wData_q;
		wStrb0_d = wStrb0_q;
		bValid_d = bValid_q;
		bResp_d = bResp_q;
		if (s_axi_awvalid && !awHeld_q) begin
			awHeld_d = 1'b1;
			awAddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeld_q) begin
			wHeld_d = 1'b1;
			wData_d = s_axi_wdata;
			wStrb0_d = s_axi_wstrb[0];
		end
		if (doWrite) begin
			awHeld_d = 1'b0;
			wHeld_d = 1'b0;
			bValid_d = 1'b1;
			bResp_d = (awAddr_q == PSCB_ADDR_CFG || awAddr_q == PSCB_ADDR_STAT)
				? PSCB_RESP_OKAY : PSCB_RESP_SLVERR;
		end
		if (bValid_q && s_axi_bready) begin
			bValid_d = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Configuration bits
	// ------------------------------------------------------------
	assign smStart = (cfgWrite && wData_q[PSCB_BIT_STATE_MACHINE_RESET_BIT])
		|| (cfgWrite && sleep_q && !wData_q[PSCB_BIT_SLEEP]);

	always_comb begin
		loop_d = loop_q;
		sleep_d = sleep_q;
		skip_d = skip_q;
		rpd_d = rpd_q;
		smBit_d = smBit_q;
		if (cfgWrite) begin
			loop_d = wData_q[PSCB_BIT_LOOPOUT];
			sleep_d = wData_q[PSCB_BIT_SLEEP];
			skip_d = wData_q[PSCB_BIT_PRESKIP];
			rpd_d = wData_q[PSCB_BIT_RPDEN];
		end
		// New start wins over completion so a rewrite in the done cycle is not lost; one during the run adds no new pulse
		if (smStart && wData_q[PSCB_BIT_STATE_MACHINE_RESET_BIT]) begin
			smBit_d = 1'b1;
		end else if (smDone) begin
			smBit_d = 1'b0;
		end
		smOut_d = smBusy || smStart;
	end

	pscb_smreset uSmReset (
		.mclk(mclk),
		.rst_b(rst_b),
		.startPulse(smStart),
		.busy(smBusy),
		.donePulse(smDone)
	);

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	always_comb begin
		rValid_d = rValid_q;
		rResp_d = rResp_q;
		rData_d = rData_q;
		if (s_axi_arvalid && !rValid_q) begin
			rValid_d = 1'b1;
			rResp_d = PSCB_RESP_OKAY;
			unique case (s_axi_araddr)
				PSCB_ADDR_CFG: rData_d = cfgView;
				PSCB_ADDR_STAT: rData_d = {{(PSCB_DATA_W-1){1'b0}}, smBusy};
				default: begin
					rData_d = '0;
					rResp_d = PSCB_RESP_SLVERR;
				end
			endcase
		end else if (rValid_q && s_axi_rready) begin
			rValid_d = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= '0;
			wData_q <= '0;
			wStrb0_q <= 1'b0;
			bValid_q <= 1'b0;
			bResp_q <= PSCB_RESP_OKAY;
			rValid_q <= 1'b0;
			rResp_q <= PSCB_RESP_OKAY;
			rData_q <= '0;
			loop_q <= PSCB_RST_LOOPOUT;
			sleep_q <= PSCB_RST_SLEEP;
			skip_q <= PSCB_RST_PRESKIP;
			rpd_q <= PSCB_RST_RPDEN;
			smBit_q <= 1'b0;
			smOut_q <= 1'b0;
			awRdy_q <= 1'b1;
			wRdy_q <= 1'b1;
			arRdy_q <= 1'b1;
		end else begin
			awHeld_q <= awHeld_d;
			wHeld_q <= wHeld_d;
			awAddr_q <= awAddr_d;
			wData_q <= wData_d;
			wStrb0_q <= wStrb0_d;
			bValid_q <= bValid_d;
			bResp_q <= bResp_d;
			rValid_q <= rValid_d;
			rResp_q <= rResp_d;
			rData_q <= rData_d;
			loop_q <= loop_d;
			sleep_q <= sleep_d;
			skip_q <= skip_d;
			rpd_q <= rpd_d;
			smBit_q <= smBit_d;
			smOut_q <= smOut_d;
			awRdy_q <= !awHeld_d;
			wRdy_q <= !wHeld_d;
			arRdy_q <= !rValid_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Ready only while the holding slot is empty; one write can be held while another awaits its response
	assign s_axi_awready = awRdy_q;
	assign s_axi_wready = wRdy_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_arready = arRdy_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rresp = rResp_q;
	assign s_axi_rdata = rData_q;
	assign smResetOut = smOut_q;
	assign preambleSkipOn = skip_q;
	assign sleepPowerDown = sleep_q;
	assign remoteLoopoutOn = loop_q;
	assign reducedPowerDownEn = rpd_q;
endmodule : pscb_top

// ### tb/pscb_chk.sv
module pscb_chk (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic smResetOut,
	input wire logic preambleSkipOn,
	input wire logic sleepPowerDown,
	input wire logic remoteLoopoutOn,
	input wire logic reducedPowerDownEn
);
	timeunit 1ns;
	timeprecision 1ps;
	// --------
	// Checks
	// --------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	rst_val_a: assert property ($rose(rst_b) |-> preambleSkipOn && reducedPowerDownEn
		&& !sleepPowerDown && !remoteLoopoutOn && !smResetOut) else $error("bad reset value");
	smr_len_a: assert property ($rose(smResetOut) |-> smResetOut[*5] ##1 !smResetOut)
		else $error("reset pulse length");
	wake_rst_a: assert property ($fell(sleepPowerDown) |-> ##[0:2] smResetOut)
		else $error("no reset on wake");
	cfg_hold_a: assert property (!$stable({preambleSkipOn, sleepPowerDown, remoteLoopoutOn,
		reducedPowerDownEn}) |-> $rose(s_axi_bvalid)) else $error("config moved without write");
	wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("no write response");
	rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read answer");
	b_hold_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
		else $error("bvalid dropped");
	r_hold_a: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
		else $error("rvalid dropped");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	cover property ($rose(smResetOut));
	cover property ($fell(sleepPowerDown));
	cover property (s_axi_rvalid && s_axi_rready);
endmodule : pscb_chk

// ### tb/pscb_mgmt.sv
module pscb_mgmt (
	input wire logic mclk,
	output logic [3:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [3:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	// Response ready raised with the request and held until the answer
	initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready,
		s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge mclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		while (!(s_axi_bvalid && s_axi_bready) && n < 50) begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end
		s_axi_bready <= 1'b0;
		s_axi_wdata <= ~d;
		if (n == 50) testbench.complete_run(1'b1);
	endtask : wr
	task automatic rd(input logic [3:0] a);
		int n;
		n = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!(s_axi_rvalid && s_axi_rready) && n < 50) begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end
		s_axi_rready <= 1'b0;
		if (n == 50) testbench.complete_run(1'b1);
	endtask : rd
endmodule : pscb_mgmt

// ### tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pscb_pkg::*;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic smResetOut, preambleSkipOn, sleepPowerDown, remoteLoopoutOn, reducedPowerDownEn;
	int n_mismatch = 0;
	int n_tests = 0;
	logic [33:0] expQ[$];
	always #20 mclk = ~mclk;
	pscb_top i_dut (.mclk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .smResetOut, .preambleSkipOn, .sleepPowerDown, .remoteLoopoutOn,
		.reducedPowerDownEn);
	pscb_mgmt i_mgmt (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic complete_run(input logic hung);
		if (hung) n_mismatch++;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : complete_run
	function automatic logic [33:0] outs();
		return {29'h0, reducedPowerDownEn, smResetOut, preambleSkipOn, sleepPowerDown, remoteLoopoutOn};
	endfunction : outs
	// One transfer at a time, so a single queue serves both answers
	always @(posedge mclk) begin
		if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
		if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, expQ.pop_front());
	end
	task automatic rd(input logic [3:0] a, input logic [33:0] e);
		expQ.push_back(e);
		i_mgmt.rd(a);
	endtask : rd
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		expQ.push_back({r, 32'h0});
		i_mgmt.wr(a, d, s);
	endtask : wr
	initial begin
		void'($urandom(32'hC576));
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		chk(outs(), 34'h14);
		rd(PSCB_ADDR_CFG, 34'h14);
		for (int i = 0; i < 12; i++) begin
			v = $urandom & 32'h17;
			wr(PSCB_ADDR_CFG, v, 4'hF, PSCB_RESP_OKAY);
			repeat (8) @(posedge mclk);
			chk(outs(), 34'(v));
			rd(PSCB_ADDR_CFG, {PSCB_RESP_OKAY, v});
		end
		wr(PSCB_ADDR_CFG, 32'h16, 4'hF, PSCB_RESP_OKAY);
		wr(PSCB_ADDR_CFG, 32'h14, 4'hF, PSCB_RESP_OKAY);
		chk(34'(smResetOut), 34'h1);
		repeat (10) @(posedge mclk);
		rd(PSCB_ADDR_CFG, {PSCB_RESP_OKAY, 32'h14});
		wr(PSCB_ADDR_CFG, 32'h1C, 4'hF, PSCB_RESP_OKAY);
		chk(34'(smResetOut), 34'h1);
		rd(PSCB_ADDR_STAT, {PSCB_RESP_OKAY, 32'h1});
		repeat (10) @(posedge mclk);
		rd(PSCB_ADDR_CFG, {PSCB_RESP_OKAY, 32'h14});
		wr(PSCB_ADDR_CFG, 32'h1C, 4'hF, PSCB_RESP_OKAY);
		rd(PSCB_ADDR_CFG, {PSCB_RESP_OKAY, 32'h1C});
		repeat (10) @(posedge mclk);
		wr(PSCB_ADDR_STAT, 32'h1F, 4'hF, PSCB_RESP_OKAY);
		wr(PSCB_ADDR_CFG, 32'h15, 4'h0, PSCB_RESP_OKAY);
		rd(4'h8, {PSCB_RESP_SLVERR, 32'h0});
		wr(4'hC, 32'h1, 4'hF, PSCB_RESP_SLVERR);
		rd(PSCB_ADDR_CFG, {PSCB_RESP_OKAY, 32'h14});
		complete_run(1'b0);
	end
endmodule : testbench
bind pscb_top pscb_chk u_chk (.mclk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .smResetOut, .preambleSkipOn, .sleepPowerDown, .remoteLoopoutOn,
	.reducedPowerDownEn);
